// File: design/i2c_slave_pkg.sv
`default_nettype none
package i2c_slave_pkg;

  // ==========================================================
  // counts, patterns and values after reset
  // ==========================================================
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] BIT_CNT_RESET = 4'h0;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;
  localparam logic [1:0] LINE_IDLE = 2'h3;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic RELEASE_RESET = 1'b1;
  localparam logic FLAG_RESET = 1'b0;

  // ==========================================================
  // engine states and byte kinds
  // ==========================================================
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_SHIFT_IN = 5'h02,
    ST_ACK_OUT = 5'h04,
    ST_SHIFT_OUT = 5'h08,
    ST_ACK_IN = 5'h10
  } eng_state_t;

  typedef enum logic [1:0] {
    K_ADDR = 2'h0,
    K_ADDR_LO = 2'h1,
    K_DATA = 2'h2
  } byte_kind_t;

endpackage
`default_nettype wire

// File: design/i2c_line_if.sv
`timescale 1ns/100ps
`default_nettype none
interface i2c_line_if;
  logic scl_lvl;
  logic sda_lvl;
  modport link (output scl_lvl, output sda_lvl);
  modport core (input scl_lvl, input sda_lvl);
endinterface
`default_nettype wire

// File: design/i2c_line_sampler.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_line_sampler (
  input wire logic link_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  i2c_line_if.link line
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] lvl;
  } smp_t;

  localparam smp_t SMP_RESET = '{
    meta: i2c_slave_pkg::LINE_IDLE,
    lvl: i2c_slave_pkg::LINE_IDLE
  };

  smp_t q;
  smp_t d;

  // two flops on the link clock before the pins are used
  always_comb begin
    d = q;
    d.meta = {scl_i, sda_i};
    d.lvl = q.meta;
  end

  always_ff @(posedge link_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= SMP_RESET;
    end else begin
      q <= d;
    end
  end

  assign line.scl_lvl = q.lvl[1];
  assign line.sda_lvl = q.lvl[0];
endmodule
`default_nettype wire

// File: design/i2c_slave_core.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_slave_core (
  input wire logic CORE_CLK_I,
  input wire logic ARST_N_I,
  input wire logic CE_I,
  input wire logic LINK_CLK_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SCL_O,
  output logic SCL_OE_O,
  output logic SDA_O,
  output logic SDA_OE_O,
  input wire logic TEN_BIT_I,
  input wire logic ADDR_HOLD_EN_I,
  input wire logic DATA_HOLD_EN_I,
  input wire logic STRETCH_EN_I,
  input wire logic START_INT_EN_I,
  input wire logic COLL_DETECT_EN_I,
  input wire logic ACK_VALUE_I,
  input wire logic BUF_WR_I,
  input wire logic [7:0] BUF_WDATA_I,
  input wire logic BUF_RD_I,
  input wire logic ADDR_WR_I,
  input wire logic [7:0] ADDR_WDATA_I,
  input wire logic CLK_RELEASE_SET_I,
  input wire logic EVENT_CLR_I,
  input wire logic COLL_CLR_I,
  output logic [7:0] BUF_RDATA_O,
  output logic [7:0] SLAVE_ADDR_O,
  output logic BUFFER_FULL_O,
  output logic CLOCK_RELEASE_O,
  output logic SERIAL_EVENT_O,
  output logic BUS_COLLISION_O,
  output logic ACK_RECEIVED_O,
  output logic UPDATE_ADDRESS_O,
  output logic START_SEEN_O,
  output logic STOP_SEEN_O,
  output logic READ_WRITE_O,
  output logic DATA_ADDR_O,
  output logic ACK_PHASE_O
);
  // ==========================================================
  // state
  // ==========================================================
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] prev;
    i2c_slave_pkg::eng_state_t st;
    i2c_slave_pkg::byte_kind_t kind;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] sbuf;
    logic [7:0] addr;
    logic bf;
    logic clock_release;
    logic ev;
    logic coll;
    logic ack_received_status;
    logic ua;
    logic start;
    logic stop;
    logic rw;
    logic da;
    logic ackph;
    logic held;
    logic hold_ack;
    logic addr10_ok;
  } core_state_t;

  localparam core_state_t RESET_STATE = '{
    sync1: i2c_slave_pkg::LINE_IDLE,
    sync2: i2c_slave_pkg::LINE_IDLE,
    prev: i2c_slave_pkg::LINE_IDLE,
    st: i2c_slave_pkg::ST_IDLE,
    kind: i2c_slave_pkg::K_ADDR,
    bitcnt: i2c_slave_pkg::BIT_CNT_RESET,
    shreg: i2c_slave_pkg::BYTE_RESET,
    sbuf: i2c_slave_pkg::BYTE_RESET,
    addr: i2c_slave_pkg::BYTE_RESET,
    clock_release: i2c_slave_pkg::RELEASE_RESET,
    default: i2c_slave_pkg::FLAG_RESET
  };

  core_state_t q;
  core_state_t d;

  function automatic logic high_hit(input logic [7:0] rx,
                                    input logic [7:0] adr);
    high_hit = (rx[7:3] == i2c_slave_pkg::TEN_BIT_PREFIX) &&
               (rx[2:1] == adr[2:1]);
  endfunction

  function automatic logic seven_hit(input logic [7:0] rx,
                                     input logic [7:0] adr);
    seven_hit = (rx[7:1] == adr[7:1]);
  endfunction

  // ==========================================================
  // line sampling on the link clock, level crossing
  // ==========================================================
  i2c_line_if line_c ();

  i2c_line_sampler u_sampler (
    .link_clk_i(LINK_CLK_I),
    .arst_n_i(ARST_N_I),
    .scl_i(SCL_I),
    .sda_i(SDA_I),
    .line(line_c)
  );

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic tx_bit;
  logic ack_nack;

  assign scl = q.sync2[1];
  assign sda = q.sync2[0];
  assign scl_rise = scl && !q.prev[1];
  assign scl_fall = !scl && q.prev[1];
  assign start_c = scl && q.prev[1] && !sda && q.prev[0];
  assign stop_c = scl && q.prev[1] && sda && !q.prev[0];
  assign tx_bit = q.sbuf[3'h7 - q.bitcnt[2:0]];
  assign ack_nack = q.hold_ack && ACK_VALUE_I;

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    d = q;
    d.sync1 = {line_c.scl_lvl, line_c.sda_lvl};
    d.sync2 = q.sync1;
    d.prev = q.sync2;
    // software side first so that hardware sets win
    if (BUF_RD_I) begin
      d.bf = 1'b0;
    end
    if (BUF_WR_I) begin
      d.sbuf = BUF_WDATA_I;
      d.bf = 1'b1;
    end
    if (EVENT_CLR_I) begin
      d.ev = 1'b0;
    end
    if (COLL_CLR_I) begin
      d.coll = 1'b0;
    end
    if (CLK_RELEASE_SET_I) begin
      d.clock_release = 1'b1;
    end
    if (ADDR_WR_I) begin
      d.addr = ADDR_WDATA_I;
      d.ua = 1'b0;
    end
    // hold only once SCL has been seen low
    d.held = (!q.clock_release || q.ua) && (q.held || !scl);
    if (start_c) begin
      d.start = 1'b1;
      d.stop = 1'b0;
      d.st = i2c_slave_pkg::ST_SHIFT_IN;
      d.kind = i2c_slave_pkg::K_ADDR;
      d.bitcnt = i2c_slave_pkg::BIT_CNT_RESET;
      d.ackph = 1'b0;
      if (START_INT_EN_I) begin
        d.ev = 1'b1;
      end
    end else if (stop_c) begin
      d.stop = 1'b1;
      d.start = 1'b0;
      d.st = i2c_slave_pkg::ST_IDLE;
      d.ackph = 1'b0;
      d.addr10_ok = 1'b0;
    end else begin
      case (q.st)
        i2c_slave_pkg::ST_SHIFT_IN: begin
          if (scl_rise) begin
            d.shreg = {q.shreg[6:0], sda};
            d.bitcnt = q.bitcnt + 4'h1;
          end
          if (scl_fall && q.bitcnt == i2c_slave_pkg::BYTE_BITS) begin
            d.bitcnt = i2c_slave_pkg::BIT_CNT_RESET;
            case (q.kind)
              i2c_slave_pkg::K_ADDR: begin
                if ((TEN_BIT_I && high_hit(q.shreg, q.addr) &&
                     (!q.shreg[0] || q.addr10_ok)) ||
                    (!TEN_BIT_I && seven_hit(q.shreg, q.addr))) begin
                  d.sbuf = q.shreg;
                  d.bf = 1'b1;
                  d.rw = q.shreg[0];
                  d.da = 1'b0;
                  d.st = i2c_slave_pkg::ST_ACK_OUT;
                  d.ackph = 1'b1;
                  d.hold_ack = ADDR_HOLD_EN_I;
                  if (TEN_BIT_I && !q.shreg[0]) begin
                    d.addr10_ok = 1'b0;
                  end
                  if (ADDR_HOLD_EN_I) begin
                    d.clock_release = 1'b0;
                    d.ev = 1'b1;
                  end
                end else begin
                  d.st = i2c_slave_pkg::ST_IDLE;
                end
              end
              i2c_slave_pkg::K_ADDR_LO: begin
                if (q.shreg == q.addr) begin
                  d.sbuf = q.shreg;
                  d.bf = 1'b1;
                  d.da = 1'b0;
                  d.st = i2c_slave_pkg::ST_ACK_OUT;
                  d.ackph = 1'b1;
                  d.addr10_ok = 1'b1;
                  d.hold_ack = ADDR_HOLD_EN_I;
                  if (ADDR_HOLD_EN_I) begin
                    d.clock_release = 1'b0;
                    d.ev = 1'b1;
                  end
                end else begin
                  // no ack, buffer and release left alone
                  d.ev = 1'b1;
                  d.ua = 1'b1;
                  d.st = i2c_slave_pkg::ST_IDLE;
                end
              end
              default: begin
                d.sbuf = q.shreg;
                d.bf = 1'b1;
                d.da = 1'b1;
                d.st = i2c_slave_pkg::ST_ACK_OUT;
                d.ackph = 1'b1;
                d.hold_ack = DATA_HOLD_EN_I;
                if (DATA_HOLD_EN_I) begin
                  d.clock_release = 1'b0;
                  d.ev = 1'b1;
                end
              end
            endcase
          end
        end
        i2c_slave_pkg::ST_ACK_OUT: begin
          if (scl_fall) begin
            d.ackph = 1'b0;
            if (ack_nack) begin
              d.st = i2c_slave_pkg::ST_IDLE;
            end else begin
              d.ev = 1'b1;
              if (q.rw && q.kind == i2c_slave_pkg::K_ADDR) begin
                // a read request stretches whatever the buffer holds
                d.clock_release = 1'b0;
                d.st = i2c_slave_pkg::ST_SHIFT_OUT;
                d.bitcnt = i2c_slave_pkg::BIT_CNT_RESET;
              end else begin
                d.st = i2c_slave_pkg::ST_SHIFT_IN;
                if (STRETCH_EN_I) begin
                  d.clock_release = 1'b0;
                end
                if (q.kind == i2c_slave_pkg::K_ADDR && TEN_BIT_I) begin
                  d.ua = 1'b1;
                  d.kind = i2c_slave_pkg::K_ADDR_LO;
                end else if (q.kind == i2c_slave_pkg::K_ADDR_LO) begin
                  d.ua = 1'b1;
                  d.kind = i2c_slave_pkg::K_DATA;
                end else begin
                  d.kind = i2c_slave_pkg::K_DATA;
                end
              end
            end
          end
        end
        i2c_slave_pkg::ST_SHIFT_OUT: begin
          if (scl_rise && tx_bit && !sda && COLL_DETECT_EN_I) begin
            d.coll = 1'b1;
            d.st = i2c_slave_pkg::ST_IDLE;
          end else if (scl_fall) begin
            d.bitcnt = q.bitcnt + 4'h1;
            if (q.bitcnt == i2c_slave_pkg::BYTE_LAST_BIT) begin
              d.bf = 1'b0;
              d.ackph = 1'b1;
              d.st = i2c_slave_pkg::ST_ACK_IN;
            end
          end
        end
        i2c_slave_pkg::ST_ACK_IN: begin
          if (scl_rise) begin
            d.ack_received_status = sda;
          end
          if (scl_fall) begin
            d.ev = 1'b1;
            d.ackph = 1'b0;
            d.bitcnt = i2c_slave_pkg::BIT_CNT_RESET;
            if (q.ack_received_status) begin
              d.st = i2c_slave_pkg::ST_IDLE;
            end else begin
              d.clock_release = 1'b0;
              d.st = i2c_slave_pkg::ST_SHIFT_OUT;
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      q <= RESET_STATE;
    end else if (CE_I) begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign SCL_O = 1'b0;
  assign SDA_O = 1'b0;
  assign SCL_OE_O = q.held;
  assign SDA_OE_O = (q.st == i2c_slave_pkg::ST_ACK_OUT && !ack_nack) ||
                    (q.st == i2c_slave_pkg::ST_SHIFT_OUT && !tx_bit);
  assign BUF_RDATA_O = q.sbuf;
  assign SLAVE_ADDR_O = q.addr;
  assign BUFFER_FULL_O = q.bf;
  assign CLOCK_RELEASE_O = q.clock_release;
  assign SERIAL_EVENT_O = q.ev;
  assign BUS_COLLISION_O = q.coll;
  assign ACK_RECEIVED_O = q.ack_received_status;
  assign UPDATE_ADDRESS_O = q.ua;
  assign START_SEEN_O = q.start;
  assign STOP_SEEN_O = q.stop;
  assign READ_WRITE_O = q.rw;
  assign DATA_ADDR_O = q.da;
  assign ACK_PHASE_O = q.ackph;

  // ==========================================================
  // assertions
  // ==========================================================
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!ARST_N_I);

  property p_coll;
    CE_I && COLL_DETECT_EN_I && q.st == i2c_slave_pkg::ST_SHIFT_OUT &&
    scl_rise && tx_bit && !sda |=> BUS_COLLISION_O &&
    q.st == i2c_slave_pkg::ST_IDLE;
  endproperty
  a_coll: assert property (p_coll)
    else $error("collision not flagged");

  property p_start;
    CE_I && start_c |=> START_SEEN_O && !STOP_SEEN_O &&
    (SERIAL_EVENT_O || !$past(START_INT_EN_I));
  endproperty
  a_start: assert property (p_start)
    else $error("start not recorded");

  property p_read_stretch;
    CE_I && q.st == i2c_slave_pkg::ST_ACK_OUT && scl_fall && q.rw &&
    q.kind == i2c_slave_pkg::K_ADDR && !ack_nack && !start_c && !stop_c
    |=> !CLOCK_RELEASE_O && SERIAL_EVENT_O &&
    q.st == i2c_slave_pkg::ST_SHIFT_OUT;
  endproperty
  a_read_stretch: assert property (p_read_stretch)
    else $error("read request did not stretch");

  property p_hold;
    CE_I && !q.clock_release && !scl |=> SCL_OE_O;
  endproperty
  a_hold: assert property (p_hold)
    else $error("SCL not held");

  property p_release;
    CE_I && CLK_RELEASE_SET_I && q.st == i2c_slave_pkg::ST_IDLE && !q.ua
    ##1 CE_I |=> CLOCK_RELEASE_O && !SCL_OE_O;
  endproperty
  a_release: assert property (p_release)
    else $error("SCL not released");

  property p_buf_wr;
    CE_I && BUF_WR_I && q.st == i2c_slave_pkg::ST_IDLE
    |=> BUFFER_FULL_O && BUF_RDATA_O == $past(BUF_WDATA_I);
  endproperty
  a_buf_wr: assert property (p_buf_wr)
    else $error("buffer write lost");

  property p_ack_received_status;
    CE_I && q.st == i2c_slave_pkg::ST_ACK_IN && scl_rise
    |=> ACK_RECEIVED_O == $past(sda);
  endproperty
  a_ack_received_status: assert property (p_ack_received_status)
    else $error("ack status wrong");

  property p_nack;
    CE_I && q.st == i2c_slave_pkg::ST_ACK_IN && scl_fall && q.ack_received_status
    |=> q.st == i2c_slave_pkg::ST_IDLE && SERIAL_EVENT_O;
  endproperty
  a_nack: assert property (p_nack)
    else $error("nack did not end transfer");

  property p_ua_clear;
    CE_I && ADDR_WR_I && !scl_fall |=> !UPDATE_ADDRESS_O;
  endproperty
  a_ua_clear: assert property (p_ua_clear)
    else $error("update flag not cleared");

  c_read: cover property (q.st == i2c_slave_pkg::ST_ACK_OUT && q.rw
                          ##1 q.st == i2c_slave_pkg::ST_SHIFT_OUT);
  c_coll: cover property ($rose(BUS_COLLISION_O));
  c_ua: cover property ($rose(UPDATE_ADDRESS_O));
  c_nack: cover property (q.st == i2c_slave_pkg::ST_ACK_IN && q.ack_received_status
                          ##1 q.st == i2c_slave_pkg::ST_IDLE);
endmodule
`default_nettype wire

// File: verif/i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model #(
  parameter int HALF_NS = 2000
) (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_o,
  output logic sda_oe_o,
  output logic done_o,
  output logic [7:0] rx_o
);
  // ==========================================================
  // bus primitives
  // ==========================================================
  initial begin
    scl_oe_o = 1'b0;
    sda_oe_o = 1'b0;
    done_o = 1'b0;
    rx_o = 8'h00;
  end

  // sda moves only a quarter phase after scl is low
  task automatic bit_io(input logic b, output logic s);
    #(HALF_NS / 4);
    sda_oe_o = ~b;
    #(HALF_NS);
    scl_oe_o = 1'b0;
    // a stretching slave keeps the high phase waiting
    wait (scl_i === 1'b1);
    #(HALF_NS);
    s = sda_i;
    scl_oe_o = 1'b1;
  endtask

  task automatic report(input logic [7:0] v);
    rx_o = v;
    done_o = 1'b1;
    #1;
    done_o = 1'b0;
  endtask

  task automatic start();
    sda_oe_o = 1'b1;
    #(HALF_NS);
    scl_oe_o = 1'b1;
  endtask

  task automatic stop();
    #(HALF_NS / 4);
    sda_oe_o = 1'b1;
    #(HALF_NS);
    scl_oe_o = 1'b0;
    wait (scl_i === 1'b1);
    #(HALF_NS);
    sda_oe_o = 1'b0;
    #(HALF_NS);
  endtask

  // reports the ack bit seen from the slave
  task automatic wr_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    report({7'h00, s});
  endtask

  // jam pulls sda low through the data bits
  task automatic rd_byte(input logic nack, input logic jam);
    logic [7:0] v;
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(~jam, v[i]);
    end
    bit_io(nack, s);
    report(v);
  endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int LIMIT = 90000;
  logic core_clk = 0, link_clk = 0, arst_n = 0, ce = 1;
  logic ten_bit = 0, a_hold = 0, d_hold = 0, str_en = 0, st_int = 1;
  logic coll_en = 1, ack_val = 0, buf_wr = 0, buf_rd = 0, addr_wr = 0;
  logic rel_set = 0, ev_clr = 0, coll_clr = 0;
  logic [7:0] buf_wd = 8'h00, addr_wd = 8'h00, rdata, saddr, m_rx, d;
  logic scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda, m_done, scl_w, sda_w;
  logic full, rel, evt, coll, ackr, ua, sts, stp, rw, da, ackph;
  int error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'h0918;
  logic [7:0] exp_q[$];

  // ==========================================================
  // wired-and lines with pull-ups, clocks, parts
  // ==========================================================
  assign scl_w = !((scl_oe && !scl_o) || m_scl);
  assign sda_w = !((sda_oe && !sda_o) || m_sda);
  always #5 core_clk = ~core_clk;
  initial begin
    #17;
    forever #62.5 link_clk = ~link_clk;
  end

  i2c_slave_core u_dut (.CORE_CLK_I(core_clk), .ARST_N_I(arst_n), .CE_I(ce),
    .LINK_CLK_I(link_clk), .SCL_I(scl_w), .SDA_I(sda_w), .SCL_O(scl_o),
    .SCL_OE_O(scl_oe), .SDA_O(sda_o), .SDA_OE_O(sda_oe), .TEN_BIT_I(ten_bit),
    .ADDR_HOLD_EN_I(a_hold), .DATA_HOLD_EN_I(d_hold), .STRETCH_EN_I(str_en),
    .START_INT_EN_I(st_int), .COLL_DETECT_EN_I(coll_en), .ACK_VALUE_I(ack_val),
    .BUF_WR_I(buf_wr), .BUF_WDATA_I(buf_wd), .BUF_RD_I(buf_rd),
    .ADDR_WR_I(addr_wr), .ADDR_WDATA_I(addr_wd), .CLK_RELEASE_SET_I(rel_set),
    .EVENT_CLR_I(ev_clr), .COLL_CLR_I(coll_clr), .BUF_RDATA_O(rdata),
    .SLAVE_ADDR_O(saddr), .BUFFER_FULL_O(full), .CLOCK_RELEASE_O(rel),
    .SERIAL_EVENT_O(evt), .BUS_COLLISION_O(coll), .ACK_RECEIVED_O(ackr),
    .UPDATE_ADDRESS_O(ua), .START_SEEN_O(sts), .STOP_SEEN_O(stp),
    .READ_WRITE_O(rw), .DATA_ADDR_O(da), .ACK_PHASE_O(ackph));

  i2c_master_model u_mst (.scl_i(scl_w), .sda_i(sda_w), .scl_oe_o(m_scl),
    .sda_oe_o(m_sda), .done_o(m_done), .rx_o(m_rx));

  // ==========================================================
  // checking
  // ==========================================================
  task automatic give_verdict();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // every byte or ack bit that the master sees is matched to its note
  always @(posedge m_done) begin
    logic [7:0] e;
    e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
    chk("bus byte", e, m_rx);
  end

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      give_verdict();
    end
  end

  // ==========================================================
  // software strobes, driven on the falling edge
  // ==========================================================
  task automatic gap(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic pulse(ref logic s);
    @(negedge core_clk);
    s = 1'b1;
    @(negedge core_clk);
    s = 1'b0;
  endtask

  task automatic sw_addr(input logic [7:0] a);
    addr_wd = a;
    pulse(addr_wr);
    gap(2);
  endtask

  task automatic wait_hold();
    for (int k = 0; k < 6000 && rel !== 1'b0 && ua !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    gap(5);
  endtask

  task automatic addr_read();
    u_mst.start();
    gap(100);
    pulse(ev_clr);
    exp_q.push_back(8'h00);
    u_mst.wr_byte(8'ha5);
    gap(100);
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  initial begin
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    arst_n = 1'b1;
    gap(20);
    pulse(rel_set);
    chk("clock_release", 8'h01, rel);
    chk("scl_drive", 8'h00, scl_oe);
    sw_addr(8'ha4);
    chk("slave_addr", 8'ha4, saddr);
    d = $random(seed);
    buf_wd = d;
    pulse(buf_wr);
    chk("buffer_full", 8'h01, full);
    chk("buffer_data", d, rdata);
    pulse(buf_rd);
    chk("buffer_full", 8'h00, full);
    // a frozen core ignores the strobe
    ce = 1'b0;
    pulse(buf_wr);
    chk("buffer_full", 8'h00, full);
    ce = 1'b1;
    // plain read of two bytes, the last one refused by the master
    u_mst.start();
    gap(100);
    chk("start_seen", 8'h01, sts);
    chk("serial_event", 8'h01, evt);
    exp_q.push_back(8'h00);
    pulse(ev_clr);
    u_mst.wr_byte(8'ha5);
    gap(100);
    chk("serial_event", 8'h01, evt);
    chk("read_write", 8'h01, rw);
    chk("clock_release", 8'h00, rel);
    chk("scl_drive", 8'h01, scl_oe);
    pulse(buf_rd);
    pulse(ev_clr);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      buf_wd = d;
      pulse(buf_wr);
      chk("clock_release", 8'h00, rel);
      pulse(rel_set);
      gap(2);
      chk("scl_drive", 8'h00, scl_oe);
      exp_q.push_back(d);
      u_mst.rd_byte(i == 1, 1'b0);
      gap(100);
      chk("ack_received", {7'h00, i == 1}, ackr);
      chk("serial_event", 8'h01, evt);
      chk("scl_drive", {7'h00, i == 0}, scl_oe);
      pulse(ev_clr);
    end
    u_mst.stop();
    gap(50);
    // address hold, software answers with a refusal
    a_hold = 1'b1;
    ack_val = 1'b1;
    u_mst.start();
    gap(100);
    pulse(ev_clr);
    exp_q.push_back(8'h01);
    fork
      u_mst.wr_byte(8'ha5);
      begin
        wait_hold();
        chk("serial_event", 8'h01, evt);
        chk("ack_phase", 8'h01, ackph);
        pulse(rel_set);
      end
    join
    u_mst.stop();
    a_hold = 1'b0;
    ack_val = 1'b0;
    // foreign address is ignored, start raises no event when disabled
    pulse(ev_clr);
    st_int = 1'b0;
    u_mst.start();
    gap(100);
    chk("start_seen", 8'h01, sts);
    chk("serial_event", 8'h00, evt);
    pulse(ev_clr);
    exp_q.push_back(8'h01);
    u_mst.wr_byte(8'h33);
    gap(100);
    chk("serial_event", 8'h00, evt);
    u_mst.stop();
    // write with stretch enable and data hold
    str_en = 1'b1;
    d_hold = 1'b1;
    u_mst.start();
    gap(100);
    exp_q.push_back(8'h00);
    u_mst.wr_byte(8'ha4);
    gap(100);
    chk("clock_release", 8'h00, rel);
    chk("scl_drive", 8'h01, scl_oe);
    chk("data_addr", 8'h00, da);
    d = $random(seed);
    pulse(ev_clr);
    pulse(buf_rd);
    pulse(rel_set);
    exp_q.push_back(8'h00);
    fork
      u_mst.wr_byte(d);
      begin
        wait_hold();
        chk("serial_event", 8'h01, evt);
        chk("data_addr", 8'h01, da);
        chk("buffer_data", d, rdata);
        pulse(ev_clr);
        pulse(rel_set);
      end
    join
    gap(100);
    chk("clock_release", 8'h00, rel);
    chk("serial_event", 8'h01, evt);
    pulse(rel_set);
    u_mst.stop();
    gap(50);
    chk("stop_seen", 8'h01, stp);
    chk("start_seen", 8'h00, sts);
    str_en = 1'b0;
    d_hold = 1'b0;
    // master jams sda while the slave sends ones, first unwatched
    addr_read();
    coll_en = 1'b0;
    buf_wd = 8'hff;
    pulse(buf_wr);
    pulse(rel_set);
    exp_q.push_back(8'h00);
    u_mst.rd_byte(1'b0, 1'b1);
    gap(100);
    chk("bus_collision", 8'h00, coll);
    chk("scl_drive", 8'h01, scl_oe);
    coll_en = 1'b1;
    pulse(ev_clr);
    pulse(buf_wr);
    pulse(rel_set);
    exp_q.push_back(8'h00);
    u_mst.rd_byte(1'b1, 1'b1);
    gap(100);
    chk("bus_collision", 8'h01, coll);
    chk("sda_drive", 8'h00, sda_oe);
    u_mst.stop();
    pulse(coll_clr);
    chk("bus_collision", 8'h00, coll);
    // ten-bit high byte, low byte update, low byte mismatch
    ten_bit = 1'b1;
    sw_addr(8'hf6);
    u_mst.start();
    gap(100);
    pulse(ev_clr);
    exp_q.push_back(8'h00);
    u_mst.wr_byte(8'hf6);
    gap(100);
    chk("update_address", 8'h01, ua);
    chk("serial_event", 8'h01, evt);
    chk("clock_release", 8'h01, rel);
    chk("scl_drive", 8'h01, scl_oe);
    pulse(ev_clr);
    sw_addr(8'h3c);
    chk("scl_drive", 8'h00, scl_oe);
    chk("update_address", 8'h00, ua);
    exp_q.push_back(8'h01);
    // a low byte mismatch holds SCL until the address is rewritten
    fork
      u_mst.wr_byte(8'h3d);
      begin
        wait_hold();
        chk("update_address", 8'h01, ua);
        chk("serial_event", 8'h01, evt);
        chk("buffer_full", 8'h01, full);
        chk("clock_release", 8'h01, rel);
        chk("scl_drive", 8'h01, scl_oe);
        sw_addr(8'hf6);
      end
    join
    u_mst.stop();
    gap(50);
    chk("pending notes", 8'h00, exp_q.size());
    give_verdict();
  end
endmodule
`default_nettype wire
